// *** common/bsl_pkg.sv ***
// Constants and types shared by the bridge limit and status registers.
// Operation
// - Indicator nibble reads constant 1, ignores writes
// - Writable 4-bit window top, resets to zero
// - Limit address bits 11:0 compare as ones
// - Limit bits 31:16 come from upper register
// - 66 MHz capable bit reads fixed one
// - Fast back-to-back capable bit reads one
// - Parity line plus response enable sets flag
// - DEVSEL timing code reads fixed medium 01
// - Signalled target abort sets its flag
// - Received target abort sets its flag
// - Received master abort sets its flag
// - System fault line sampled low sets flag
// - Detected parity error always sets flag
package bsl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_LIM_STAT = 8'h1C;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam logic [7:0] OFF_LIM_UP = 8'h44;
  localparam logic [7:0] OFF_INT_STAT = 8'h48;
  localparam logic [7:0] OFF_INT_MASK = 8'h4C;

  // Field positions in the limit and status word
  localparam int IND_LSB = 8;
  localparam int TOP_LSB = 12;
  localparam int BIT_66 = 21;
  localparam int BIT_FB2B = 23;
  localparam int BIT_DPE = 24;
  localparam int DEVSEL_LSB = 25;
  localparam int BIT_STA = 27;
  localparam int BIT_RTA = 28;
  localparam int BIT_RMA = 29;
  localparam int BIT_RSE = 30;
  localparam int BIT_DTPE = 31;

  // Field positions in the control register
  localparam int CTRL_PRESP = 6;

  // Fixed and reset values
  localparam logic [3:0] IND_VAL = 4'h1;
  localparam logic [3:0] TOP_RESET = 4'h0;
  localparam logic [15:0] LIM_UP_RESET = 16'h0000;
  localparam logic [11:0] LOW_ONES = 12'hFFF;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic CAP_66 = 1'b1;
  localparam logic CAP_FB2B = 1'b1;

  // Event flag indices
  localparam int NUM_EVT = 6;
  localparam int EV_DPE = 0;
  localparam int EV_STA = 1;
  localparam int EV_RTA = 2;
  localparam int EV_RMA = 3;
  localparam int EV_RSE = 4;
  localparam int EV_DTPE = 5;

  // Bus phase of the register slave
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } bsl_apb_st_t;

endpackage

// *** core/bsl_flags.sv ***
// Sticky event flags with write-one-to-clear, set winning over clear.
`timescale 1ns/1ns
`default_nettype none
module bsl_flags #(
  parameter int N = 6
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [N-1:0] i_set,
  input wire logic [N-1:0] i_clr,
  output logic [N-1:0] o_flag
);

  // One flop per flag
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_flag
      // A set in the clearing cycle is kept
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          o_flag[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_flag[g] <= 1'b1;
        end else if (i_clr[g]) begin
          o_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** core/bsl_irq.sv ***
// Interrupt status (clear on read), mask and level request output.
`timescale 1ns/1ns
`default_nettype none
module bsl_irq #(
  parameter int N = 6
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [N-1:0] i_evt,
  input wire logic [N-1:0] i_rd_clr,
  input wire logic i_mask_we,
  input wire logic [N-1:0] i_mask_wdata,
  output logic [N-1:0] o_stat,
  output logic [N-1:0] o_mask,
  output logic o_irq
);

  // Sticky status; only bits already seen by the read are cleared
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_stat <= '0;
    end else begin
      o_stat <= (o_stat & ~i_rd_clr) | i_evt;
    end
  end

  // Mask register, one enables the source
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_mask <= '0;
    end else if (i_mask_we) begin
      o_mask <= i_mask_wdata;
    end
  end

  // Level request from flops only
  assign o_irq = |(o_stat & o_mask);

endmodule
`default_nettype wire

// *** core/bsl_regs.sv ***
// I/O window top and downstream bus condition registers behind APB.
`timescale 1ns/1ns
`default_nettype none
module bsl_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and synchronous reset
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  // APB slave port
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // Downstream bus event inputs
  input wire logic I_DOWNSTREAM_PARITY_FAULT_LINE_N,
  input wire logic I_DOWNSTREAM_SYSTEM_FAULT_LINE_N,
  input wire logic I_TARGET_ABORT_SIGNALLED,
  input wire logic I_TARGET_ABORT_RECEIVED,
  input wire logic I_MASTER_ABORT_RECEIVED,
  input wire logic I_PARITY_ERROR_DETECTED,
  // I/O window compare
  input wire logic [31:0] I_IO_ADDR,
  output logic [31:0] O_IO_LIMIT_ADDR,
  output logic O_IO_AT_OR_BELOW_LIMIT,
  // Parity response enable as seen by the bus side
  output logic O_PARITY_RESPONSE_EN,
  // Interrupt request, level
  output logic O_IRQ
);

  // Decode of one register offset, used by read and write paths
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0] off
  );
    // Word compare at full width; byte lane bits are ignored
    reg_hit = ({addr[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
  endfunction

  // Any mapped register
  function automatic logic reg_mapped(
    input logic [ADDR_W-1:0] addr
  );
    reg_mapped = reg_hit(addr, bsl_pkg::OFF_LIM_STAT) ||
                 reg_hit(addr, bsl_pkg::OFF_CTRL) ||
                 reg_hit(addr, bsl_pkg::OFF_LIM_UP) ||
                 reg_hit(addr, bsl_pkg::OFF_INT_STAT) ||
                 reg_hit(addr, bsl_pkg::OFF_INT_MASK);
  endfunction

  // Bus phase
  bsl_pkg::bsl_apb_st_t state;
  bsl_pkg::bsl_apb_st_t next_state;

  // Request latched at setup
  logic [ADDR_W-1:0] req_addr;
  // Read data snapshot taken at setup
  logic [31:0] rd_snap;
  // Combinational read mux output
  logic [31:0] rd_mux;
  // Access completes this edge
  logic acc_done;
  // Write and read strobes at the completing edge
  logic wr_go;
  logic rd_go;

  // Window top field and upper limit half
  logic [3:0] io_top;
  logic [15:0] io_lim_up;
  // Parity response enable
  logic presp_en;

  // Event sources and sticky flags
  logic [bsl_pkg::NUM_EVT-1:0] evt;
  logic [bsl_pkg::NUM_EVT-1:0] flag_clr;
  logic [bsl_pkg::NUM_EVT-1:0] flag;
  // Interrupt side
  logic [bsl_pkg::NUM_EVT-1:0] int_stat;
  logic [bsl_pkg::NUM_EVT-1:0] int_mask;
  logic [bsl_pkg::NUM_EVT-1:0] int_rd_clr;
  logic int_mask_we;

  // Assembled status halfword
  logic [15:0] stat_half;
  // Byte-lane write data of the status halfword
  logic [15:0] stat_w1c;

  // Phase tracking: setup moves to access, access ends next edge
  always_comb begin
    next_state = state;
    case (state)
      bsl_pkg::ST_IDLE: begin
        // Setup cycle seen
        if (I_PSEL && !I_PENABLE) begin
          next_state = bsl_pkg::ST_ACCESS;
        end
      end
      bsl_pkg::ST_ACCESS: begin
        // Zero wait state, always done here
        next_state = bsl_pkg::ST_IDLE;
      end
      default: begin
        // Recover from an illegal code
        next_state = bsl_pkg::ST_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      state <= bsl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready is high through the access cycle only
  assign O_PREADY = (state == bsl_pkg::ST_ACCESS);
  // Completion needs the master still in access
  assign acc_done = O_PREADY && I_PSEL && I_PENABLE;
  assign wr_go = acc_done && I_PWRITE;
  assign rd_go = acc_done && !I_PWRITE;

  // Unmapped address answers with an error alongside ready
  assign O_PSLVERR = O_PREADY && !reg_mapped(req_addr);

  // Address captured at setup for the error answer
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      req_addr <= '0;
    end else if (state == bsl_pkg::ST_IDLE && I_PSEL && !I_PENABLE) begin
      req_addr <= I_PADDR;
    end
  end

  // Status halfword layout; reserved bits are tied low
  always_comb begin
    stat_half = 16'h0000;
    stat_half[bsl_pkg::BIT_66 - 16] = bsl_pkg::CAP_66;
    stat_half[bsl_pkg::BIT_FB2B - 16] = bsl_pkg::CAP_FB2B;
    stat_half[bsl_pkg::BIT_DPE - 16] = flag[bsl_pkg::EV_DPE];
    stat_half[bsl_pkg::DEVSEL_LSB - 16 +: 2] =
      bsl_pkg::DEVSEL_MEDIUM;
    stat_half[bsl_pkg::BIT_STA - 16] = flag[bsl_pkg::EV_STA];
    stat_half[bsl_pkg::BIT_RTA - 16] = flag[bsl_pkg::EV_RTA];
    stat_half[bsl_pkg::BIT_RMA - 16] = flag[bsl_pkg::EV_RMA];
    stat_half[bsl_pkg::BIT_RSE - 16] = flag[bsl_pkg::EV_RSE];
    stat_half[bsl_pkg::BIT_DTPE - 16] = flag[bsl_pkg::EV_DTPE];
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(I_PADDR, bsl_pkg::OFF_LIM_STAT)) begin
      // Low byte belongs to the base register, not held here
      rd_mux[bsl_pkg::IND_LSB +: 4] = bsl_pkg::IND_VAL;
      rd_mux[bsl_pkg::TOP_LSB +: 4] = io_top;
      rd_mux[31:16] = stat_half;
    end else if (reg_hit(I_PADDR, bsl_pkg::OFF_CTRL)) begin
      rd_mux[bsl_pkg::CTRL_PRESP] = presp_en;
    end else if (reg_hit(I_PADDR, bsl_pkg::OFF_LIM_UP)) begin
      rd_mux[15:0] = io_lim_up;
    end else if (reg_hit(I_PADDR, bsl_pkg::OFF_INT_STAT)) begin
      rd_mux[bsl_pkg::NUM_EVT-1:0] = int_stat;
    end else if (reg_hit(I_PADDR, bsl_pkg::OFF_INT_MASK)) begin
      rd_mux[bsl_pkg::NUM_EVT-1:0] = int_mask;
    end
  end

  // Read data from a flop, taken at setup so it is steady in access
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      rd_snap <= 32'h0000_0000;
    end else if (state == bsl_pkg::ST_IDLE && I_PSEL && !I_PENABLE) begin
      rd_snap <= rd_mux;
    end
  end
  assign O_PRDATA = rd_snap;

  // Window top field, byte lane 1; indicator nibble is not stored
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      io_top <= bsl_pkg::TOP_RESET;
    end else if (wr_go && I_PSTRB[1] &&
                 reg_hit(req_addr, bsl_pkg::OFF_LIM_STAT)) begin
      io_top <= I_PWDATA[bsl_pkg::TOP_LSB +: 4];
    end
  end

  // Upper half of the limit, lanes 0 and 1
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      io_lim_up <= bsl_pkg::LIM_UP_RESET;
    end else if (wr_go && reg_hit(req_addr, bsl_pkg::OFF_LIM_UP)) begin
      if (I_PSTRB[0]) begin
        io_lim_up[7:0] <= I_PWDATA[7:0];
      end
      if (I_PSTRB[1]) begin
        io_lim_up[15:8] <= I_PWDATA[15:8];
      end
    end
  end

  // Parity response enable, lane 0
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      presp_en <= 1'b0;
    end else if (wr_go && I_PSTRB[0] &&
                 reg_hit(req_addr, bsl_pkg::OFF_CTRL)) begin
      presp_en <= I_PWDATA[bsl_pkg::CTRL_PRESP];
    end
  end
  assign O_PARITY_RESPONSE_EN = presp_en;

  // Full limit address; low bits read as ones for the compare
  assign O_IO_LIMIT_ADDR = {io_lim_up, io_top, bsl_pkg::LOW_ONES};

  // Registered compare keeps the data output on a flop
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      O_IO_AT_OR_BELOW_LIMIT <= 1'b0;
    end else begin
      O_IO_AT_OR_BELOW_LIMIT <= (I_IO_ADDR <= O_IO_LIMIT_ADDR);
    end
  end

  // Event sources; the two fault lines are active low, all taken as synchronous
  always_comb begin
    evt = '0;
    // Parity line counts only with response enabled
    evt[bsl_pkg::EV_DPE] =
      !I_DOWNSTREAM_PARITY_FAULT_LINE_N && presp_en;
    evt[bsl_pkg::EV_STA] = I_TARGET_ABORT_SIGNALLED;
    evt[bsl_pkg::EV_RTA] = I_TARGET_ABORT_RECEIVED;
    evt[bsl_pkg::EV_RMA] = I_MASTER_ABORT_RECEIVED;
    evt[bsl_pkg::EV_RSE] = !I_DOWNSTREAM_SYSTEM_FAULT_LINE_N;
    // No enable gate here by design
    evt[bsl_pkg::EV_DTPE] = I_PARITY_ERROR_DETECTED;
  end

  // Write-one-to-clear data, honouring byte lanes 2 and 3
  always_comb begin
    stat_w1c = 16'h0000;
    if (wr_go && reg_hit(req_addr, bsl_pkg::OFF_LIM_STAT)) begin
      if (I_PSTRB[2]) begin
        stat_w1c[7:0] = I_PWDATA[23:16];
      end
      if (I_PSTRB[3]) begin
        stat_w1c[15:8] = I_PWDATA[31:24];
      end
    end
  end

  // Map cleared bit positions onto flag indices
  always_comb begin
    flag_clr = '0;
    flag_clr[bsl_pkg::EV_DPE] = stat_w1c[bsl_pkg::BIT_DPE - 16];
    flag_clr[bsl_pkg::EV_STA] = stat_w1c[bsl_pkg::BIT_STA - 16];
    flag_clr[bsl_pkg::EV_RTA] = stat_w1c[bsl_pkg::BIT_RTA - 16];
    flag_clr[bsl_pkg::EV_RMA] = stat_w1c[bsl_pkg::BIT_RMA - 16];
    flag_clr[bsl_pkg::EV_RSE] = stat_w1c[bsl_pkg::BIT_RSE - 16];
    flag_clr[bsl_pkg::EV_DTPE] = stat_w1c[bsl_pkg::BIT_DTPE - 16];
  end

  // Sticky flags of the status halfword
  bsl_flags #(
    .N(bsl_pkg::NUM_EVT)
  ) u_flags (
    .i_clk(I_REF_CLK),
    .i_resetn(I_RESETN),
    .i_set(evt),
    .i_clr(flag_clr),
    .o_flag(flag)
  );

  // Read clear covers only what the snapshot showed, so an event
  // landing between setup and access is not lost
  always_comb begin
    int_rd_clr = '0;
    if (rd_go && reg_hit(req_addr, bsl_pkg::OFF_INT_STAT)) begin
      int_rd_clr = rd_snap[bsl_pkg::NUM_EVT-1:0];
    end
  end

  // Mask write on lane 0
  assign int_mask_we = wr_go && I_PSTRB[0] &&
                       reg_hit(req_addr, bsl_pkg::OFF_INT_MASK);

  // Interrupt status, mask and request
  bsl_irq #(
    .N(bsl_pkg::NUM_EVT)
  ) u_irq (
    .i_clk(I_REF_CLK),
    .i_resetn(I_RESETN),
    .i_evt(evt),
    .i_rd_clr(int_rd_clr),
    .i_mask_we(int_mask_we),
    .i_mask_wdata(I_PWDATA[bsl_pkg::NUM_EVT-1:0]),
    .o_stat(int_stat),
    .o_mask(int_mask),
    .o_irq(O_IRQ)
  );

endmodule
`default_nettype wire

// *** tb/bsl_regs_props.sv ***
// Concurrent checks on the limit and downstream status register block.
`timescale 1ns/1ns
`default_nettype none
module bsl_regs_props #(
  parameter int ADDR_W = 8
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic I_DOWNSTREAM_PARITY_FAULT_LINE_N,
  input wire logic I_DOWNSTREAM_SYSTEM_FAULT_LINE_N,
  input wire logic I_TARGET_ABORT_SIGNALLED,
  input wire logic I_TARGET_ABORT_RECEIVED,
  input wire logic I_MASTER_ABORT_RECEIVED,
  input wire logic I_PARITY_ERROR_DETECTED,
  input wire logic [31:0] I_IO_ADDR,
  input wire logic O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic [31:0] O_IO_LIMIT_ADDR,
  input wire logic O_IO_AT_OR_BELOW_LIMIT,
  input wire logic O_PARITY_RESPONSE_EN
);
  // Setup cycle of a read of the status word
  logic rd_stat;
  assign rd_stat = I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR[7:2] == 6'h07;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESETN);

  // Bus phases
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence s_rd_stat;
    rd_stat;
  endsequence

  AST_READY: assert property (s_setup |=> O_PREADY)
    else $error("no ready after setup");
  AST_NO_READY: assert property (!(I_PSEL && !I_PENABLE) |=> !O_PREADY)
    else $error("ready without setup");
  AST_IND: assert property (s_rd_stat |=> O_PRDATA[11:8] == 4'h1)
    else $error("indicator nibble wrong");
  AST_CAPS: assert property (
    s_rd_stat |=> O_PRDATA[23:16] == 8'hA0 && O_PRDATA[26:25] == 2'h1)
    else $error("fixed status bits wrong");
  AST_LIM_LOW: assert property (O_IO_LIMIT_ADDR[11:0] == 12'hFFF)
    else $error("limit low bits not ones");
  // Compare result trails its inputs by one cycle
  AST_CMP: assert property ($past(I_RESETN) |->
    O_IO_AT_OR_BELOW_LIMIT == ($past(I_IO_ADDR) <= $past(O_IO_LIMIT_ADDR)))
    else $error("window compare wrong");
  AST_DPE: assert property (
    (!I_DOWNSTREAM_PARITY_FAULT_LINE_N && O_PARITY_RESPONSE_EN) ##1
    s_rd_stat |=> O_PRDATA[24])
    else $error("data parity flag not set");
  AST_STA: assert property (
    I_TARGET_ABORT_SIGNALLED ##1 s_rd_stat |=> O_PRDATA[27])
    else $error("signalled abort flag not set");
  AST_RTA: assert property (
    I_TARGET_ABORT_RECEIVED ##1 s_rd_stat |=> O_PRDATA[28])
    else $error("received abort flag not set");
  AST_RMA: assert property (
    I_MASTER_ABORT_RECEIVED ##1 s_rd_stat |=> O_PRDATA[29])
    else $error("master abort flag not set");
  AST_RSE: assert property (
    !I_DOWNSTREAM_SYSTEM_FAULT_LINE_N ##1 s_rd_stat |=> O_PRDATA[30])
    else $error("system fault flag not set");
  AST_DTPE: assert property (
    I_PARITY_ERROR_DETECTED ##1 s_rd_stat |=> O_PRDATA[31])
    else $error("detected parity flag not set");
endmodule

bind bsl_regs bsl_regs_props #(.ADDR_W(ADDR_W)) bsl_regs_props_i (
  .I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_DOWNSTREAM_PARITY_FAULT_LINE_N(I_DOWNSTREAM_PARITY_FAULT_LINE_N),
  .I_DOWNSTREAM_SYSTEM_FAULT_LINE_N(I_DOWNSTREAM_SYSTEM_FAULT_LINE_N),
  .I_TARGET_ABORT_SIGNALLED(I_TARGET_ABORT_SIGNALLED),
  .I_TARGET_ABORT_RECEIVED(I_TARGET_ABORT_RECEIVED),
  .I_MASTER_ABORT_RECEIVED(I_MASTER_ABORT_RECEIVED),
  .I_PARITY_ERROR_DETECTED(I_PARITY_ERROR_DETECTED),
  .I_IO_ADDR(I_IO_ADDR), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA),
  .O_IO_LIMIT_ADDR(O_IO_LIMIT_ADDR),
  .O_IO_AT_OR_BELOW_LIMIT(O_IO_AT_OR_BELOW_LIMIT),
  .O_PARITY_RESPONSE_EN(O_PARITY_RESPONSE_EN)
);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the limit and downstream status registers.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk; // Reference clock
  logic resetn; // Synchronous reset, active low
  logic psel, penable, pwrite; // APB request
  logic [7:0] paddr; // Byte address
  logic [31:0] pwdata; // Write data
  logic [5:0] ev; // Event lines, interrupt bit order
  logic [31:0] io_addr; // Address under compare
  logic pready, pslverr, irq, presp, below; // Design outputs
  logic [31:0] prdata, lim; // Read data and limit word
  int fails, n_compared, cyc; // Counters
  int pos [6] = '{24, 27, 28, 29, 30, 31}; // Flag position per event
  logic [31:0] fm; // Flag bit under test

  bsl_regs #(.ADDR_W(8)) bsl_regs_i (
    .I_REF_CLK(clk), .I_RESETN(resetn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr),
    .I_DOWNSTREAM_PARITY_FAULT_LINE_N(~ev[0]),
    .I_DOWNSTREAM_SYSTEM_FAULT_LINE_N(~ev[4]),
    .I_TARGET_ABORT_SIGNALLED(ev[1]), .I_TARGET_ABORT_RECEIVED(ev[2]),
    .I_MASTER_ABORT_RECEIVED(ev[3]), .I_PARITY_ERROR_DETECTED(ev[5]),
    .I_IO_ADDR(io_addr), .O_IO_LIMIT_ADDR(lim),
    .O_IO_AT_OR_BELOW_LIMIT(below), .O_PARITY_RESPONSE_EN(presp),
    .O_IRQ(irq)
  );

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict, reached from the main flow or the hang guard
  task automatic final_report;
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the 120 or so cycles needed
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 3000) begin
        fails++;
        $display("mismatch at %0t: timeout", $time);
        final_report;
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Drive only just after a rising edge
  task automatic sync;
    if (clk !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  // One APB transfer; answer taken at the edge that sees ready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] exp,
                      input logic xe);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    sync;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until ready is seen; only the hang guard ends it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    // Values sampled at this edge are those of the access cycle
    r = prdata;
    e = pslverr;
    // Slave answers with no wait state
    chk(n, 32'h1, "wait states");
    if (!w) begin
      chk(r, exp, "read data");
    end
    chk({31'h0, e}, {31'h0, xe}, "slave error");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, exp, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  // Bus released, outputs looked at mid-cycle
  task automatic settle;
    sync;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  // One-cycle event; the next call may start a read at once
  task automatic pulse(input logic [5:0] e);
    sync;
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
  endtask

  // Window compare settles one cycle after the address
  task automatic cmp(input logic [31:0] a, input logic exp);
    sync;
    io_addr <= a;
    @(posedge clk);
    settle;
    chk({31'h0, below}, {31'h0, exp}, "window compare");
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 6'h00;
    io_addr = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h1C, 32'h02A0_0100);
    settle;
    chk(lim, 32'h0000_0FFF, "limit at reset");
    // Interrupt raised, masked and cleared by reading
    wr(8'h4C, 32'h0000_0002);
    rd(8'h4C, 32'h0000_0002);
    pulse(6'h02);
    settle;
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(8'h48, 32'h0000_0002);
    settle;
    chk({31'h0, irq}, 32'h0, "irq after read");
    pulse(6'h04);
    settle;
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(8'h48, 32'h0000_0004);
    // All ones: only the top field and flag clears take effect
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h02A0_F100);
    wr(8'h1C, 32'h0000_5000);
    wr(8'h44, 32'h0000_1234);
    cmp(32'h1234_5FFF, 1'b1);
    chk(lim, 32'h1234_5FFF, "limit word");
    cmp(32'h1234_6000, 1'b0);
    cmp(32'h0000_0000, 1'b1);
    // Parity line ignored until the response enable is set
    pulse(6'h01);
    rd(8'h1C, 32'h02A0_5100);
    wr(8'h40, 32'h0000_0040);
    settle;
    chk({31'h0, presp}, 32'h1, "parity response");
    // Each event sets its flag; write zero keeps, write one clears
    for (int i = 0; i < 6; i++) begin
      fm = 32'h1 << pos[i];
      pulse(6'h01 << i);
      rd(8'h1C, 32'h02A0_5100 | fm);
      wr(8'h1C, 32'h0000_5000);
      rd(8'h1C, 32'h02A0_5100 | fm);
      wr(8'h1C, 32'h0000_5000 | fm);
      rd(8'h1C, 32'h02A0_5100);
    end
    // Unmapped place refused both ways
    xfer(1'b0, 8'h80, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, 8'h80, 32'hFFFF_FFFF, 32'h0, 1'b1);
    rd(8'h1C, 32'h02A0_5100);
    final_report;
  end
endmodule
`default_nettype wire
